// ===== inc/pmpc_pkg.sv
package pmpc_pkg;

   // Bus geometry.
   localparam int          ADDR_W       = 12;
   localparam int          DATA_W       = 32;

   // Pin counts covered by the three configuration words.
   localparam int          B1_PINS      = 18;
   localparam int          B1_LO_PINS   = 16;
   localparam int          B0_PINS      = 16;

   // Register byte offsets.
   localparam logic [11:0] OFS_B1_MODE_LO = 12'h008;
   localparam logic [11:0] OFS_B1_MODE_HI = 12'h00C;
   localparam logic [11:0] OFS_B0_PULL_LO = 12'h010;
   localparam logic [11:0] OFS_B0_IN_STAT = 12'h040;

   // Writable bits of each word; reserved pairs are held at zero.
   localparam logic [31:0] MASK_B1_MODE_LO = 32'hFCF3_FCFF;
   localparam logic [31:0] MASK_B1_MODE_HI = 32'h0000_000F;
   localparam logic [31:0] MASK_B0_PULL_LO = 32'hFFFF_FF3F;

   // Values after reset.
   localparam logic [31:0] RST_B1_MODE_LO = 32'h0000_0000;
   localparam logic [31:0] RST_B1_MODE_HI = 32'h0000_0000;
   localparam logic [31:0] RST_B0_PULL_LO = 32'h0000_0000;
   localparam logic [31:0] RST_ZERO       = 32'h0000_0000;

   // Full-word byte strobe.
   localparam logic [3:0]  STRB_WORD      = 4'hF;

   // Index of each register in the one-hot select vectors.
   localparam int          SEL_B1_LO  = 0;
   localparam int          SEL_B1_HI  = 1;
   localparam int          SEL_B0_PL  = 2;
   localparam int          SEL_STAT   = 3;
   localparam int          SEL_W      = 4;

   // Output drive mode field encoding.
   typedef enum logic [1:0] {
      PMPC_PUSH_PULL   = 2'h0,
      PMPC_OPEN_DRAIN  = 2'h1,
      PMPC_OPEN_SOURCE = 2'h2,
      PMPC_DRIVE_RSVD  = 2'h3
   } pmpc_drive_type;

   // Pull selection field encoding.
   typedef enum logic [1:0] {
      PMPC_PULL_FLOAT  = 2'h0,
      PMPC_PULL_UP     = 2'h1,
      PMPC_PULL_DOWN   = 2'h2,
      PMPC_PULL_ANALOG = 2'h3
   } pmpc_pull_type;

endpackage

// ===== inc/pmpc_bus_if.sv
`timescale 1ns/100ps
interface pmpc_bus_if;
   logic [pmpc_pkg::SEL_W-1:0]  wr_stb;
   logic [pmpc_pkg::DATA_W-1:0] wdata;
   logic [pmpc_pkg::SEL_W-1:0]  rd_sel;
   logic [pmpc_pkg::DATA_W-1:0] rdata;

   modport slave (output wr_stb, output wdata, output rd_sel, input rdata);
   modport core  (input wr_stb, input wdata, input rd_sel, output rdata);
endinterface

// ===== verilog/pmpc_apb_slave.sv
`timescale 1ns/100ps
module pmpc_apb_slave (
   input  wire logic                        clock,   // System clock.
   input  wire logic                        rstn,    // Synchronous reset, active low.
   input  wire logic                        psel,    // APB select.
   input  wire logic                        penable, // APB enable.
   input  wire logic                        pwrite,  // APB direction, high for write.
   input  wire logic [pmpc_pkg::ADDR_W-1:0] paddr,   // APB byte address.
   input  wire logic [pmpc_pkg::DATA_W-1:0] pwdata,  // APB write data.
   input  wire logic [3:0]                  pstrb,   // APB byte strobes.
   output logic      [pmpc_pkg::DATA_W-1:0] prdata,  // APB read data.
   output logic                             pready,  // APB ready.
   output logic                             pslverr, // APB error.
   pmpc_bus_if.slave                        bus      // Strobes toward the register core.
);

   logic [pmpc_pkg::SEL_W-1:0] hit;
   logic                       setup;
   logic                       bad_strb;

   // Address decode; a misaligned address matches nothing.
   always_comb begin
      hit = '0;
      case (paddr)
         pmpc_pkg::OFS_B1_MODE_LO: hit[pmpc_pkg::SEL_B1_LO] = 1'b1;
         pmpc_pkg::OFS_B1_MODE_HI: hit[pmpc_pkg::SEL_B1_HI] = 1'b1;
         pmpc_pkg::OFS_B0_PULL_LO: hit[pmpc_pkg::SEL_B0_PL] = 1'b1;
         pmpc_pkg::OFS_B0_IN_STAT: hit[pmpc_pkg::SEL_STAT]  = 1'b1;
         default:                  hit = '0;
      endcase
   end

   assign setup    = psel & ~penable;
   // Only whole-word writes are accepted; partial lanes would tear a field pair.
   assign bad_strb = pwrite & (pstrb != pmpc_pkg::STRB_WORD);

   // Every transfer finishes in its first access cycle, so pready follows setup.
   always_ff @(posedge clock) begin
      if (!rstn) begin
         pready  <= 1'b0;
         pslverr <= 1'b0;
      end else begin
         pready  <= setup;
         pslverr <= setup & ((hit == '0) | bad_strb);
      end
   end

   // Read data is captured during setup so it comes straight from a flop.
   always_ff @(posedge clock) begin
      if (!rstn) begin
         prdata <= pmpc_pkg::RST_ZERO;
      end else if (setup && !pwrite) begin
         prdata <= bus.rdata;
      end else if (!psel) begin
         prdata <= pmpc_pkg::RST_ZERO;
      end
   end

   assign bus.rd_sel = hit;
   assign bus.wdata  = pwdata;
   // Writes land on the edge that completes the access phase.
   assign bus.wr_stb = (psel & penable & pready & pwrite & ~pslverr) ? hit : '0;

endmodule

// ===== verilog/pmpc_top.sv
`timescale 1ns/100ps
// Function
// - Bank one drive mode low word at 0x08, pairs 25:24,19:18,9:8 reserved, reset zero.
// - Bank one drive mode high word at 0x0C, two fields, bits 31:4 reserved.
// - Bank zero pull select word at 0x10, pair 7:6 reserved, reset zero.
// - Pull code 00 leaves the pin floating, and is the reset state.
// - Pull code 01 pulls up, 10 pulls down, 11 selects analog.
// - Fields change only on software writes and otherwise hold their value.
// - Drive code 00 push-pull, 01 open-drain, 10 open-source, 11 reserved.
// - Analog pins lose pulls and trigger; input status reads zero.
module pmpc_top (
   input  wire logic                        clock,             // System clock, 40 MHz.
   input  wire logic                        rstn,              // Synchronous reset, active low.
   input  wire logic                        psel,              // APB select.
   input  wire logic                        penable,           // APB enable.
   input  wire logic                        pwrite,            // APB direction.
   input  wire logic [pmpc_pkg::ADDR_W-1:0] paddr,             // APB byte address.
   input  wire logic [pmpc_pkg::DATA_W-1:0] pwdata,            // APB write data.
   input  wire logic [3:0]                  pstrb,             // APB byte strobes.
   output logic      [pmpc_pkg::DATA_W-1:0] prdata,            // APB read data.
   output logic                             pready,            // APB ready.
   output logic                             pslverr,           // APB error.
   input  wire logic [pmpc_pkg::B1_PINS-1:0] b1_out_data,      // Bank one data to drive.
   output logic      [pmpc_pkg::B1_PINS-1:0] b1_pad_o,         // Bank one pad output level.
   output logic      [pmpc_pkg::B1_PINS-1:0] b1_pad_oe_n,      // Bank one drive enable, low.
   output logic      [pmpc_pkg::B1_PINS-1:0] b1_open_drain_en, // Bank one open-drain mode.
   output logic      [pmpc_pkg::B1_PINS-1:0] b1_open_src_en,   // Bank one open-source mode.
   input  wire logic [pmpc_pkg::B0_PINS-1:0] b0_pad_in,        // Bank zero raw pad inputs.
   output logic      [pmpc_pkg::B0_PINS-1:0] b0_in_status,     // Bank zero gated inputs.
   output logic      [pmpc_pkg::B0_PINS-1:0] b0_pull_up_en,    // Bank zero weak pull-up.
   output logic      [pmpc_pkg::B0_PINS-1:0] b0_pull_down_en,  // Bank zero weak pull-down.
   output logic      [pmpc_pkg::B0_PINS-1:0] b0_analog_en,     // Bank zero analog switch.
   output logic      [pmpc_pkg::B0_PINS-1:0] b0_trig_en        // Bank zero input trigger.
);

   // Strobes and data between the bus front end and the register words.
   pmpc_bus_if bus ();

   // Stored configuration words and their next values.
   logic [pmpc_pkg::DATA_W-1:0]  b1_mode_lo_r;
   logic [pmpc_pkg::DATA_W-1:0]  b1_mode_lo_nxt;
   logic [pmpc_pkg::DATA_W-1:0]  b1_mode_hi_r;
   logic [pmpc_pkg::DATA_W-1:0]  b1_mode_hi_nxt;
   logic [pmpc_pkg::DATA_W-1:0]  b0_pull_lo_r;
   logic [pmpc_pkg::DATA_W-1:0]  b0_pull_lo_nxt;

   // Decoded pad controls, one edge ahead of the output flops.
   logic [2*pmpc_pkg::B1_PINS-1:0] b1_fields_nxt;
   logic [pmpc_pkg::B1_PINS-1:0] od_nxt;
   logic [pmpc_pkg::B1_PINS-1:0] os_nxt;
   logic [pmpc_pkg::B1_PINS-1:0] drv_o_nxt;
   logic [pmpc_pkg::B1_PINS-1:0] drv_oe_n_nxt;
   logic [pmpc_pkg::B0_PINS-1:0] pu_nxt;
   logic [pmpc_pkg::B0_PINS-1:0] pd_nxt;
   logic [pmpc_pkg::B0_PINS-1:0] an_nxt;

   // Reserved bits are forced to zero so a careless write cannot set them.
   function automatic logic [31:0] masked_write(input logic [31:0] data,
                                                input logic [31:0] mask);
      masked_write = data & mask;
   endfunction

   // Next value of one word: the written value on its strobe, else unchanged.
   function automatic logic [31:0] word_next(input logic        stb,
                                             input logic [31:0] data,
                                             input logic [31:0] mask,
                                             input logic [31:0] cur);
      if (stb) begin
         word_next = masked_write(data, mask);
      end else begin
         word_next = cur;
      end
   endfunction

   // Two-bit field of one pin; pin i sits at bits 2i+1:2i of the field vector.
   function automatic logic [1:0] field_of(input logic [35:0] fields,
                                           input int          pin);
      field_of = fields[2*pin +: 2];
   endfunction

   // Active-low drive enable of one pin. Open-drain can only sink and open-source
   // only source, so the buffer is released for the level it cannot make.
   function automatic logic oe_n_of(input logic od,
                                    input logic os,
                                    input logic data);
      if (od) begin
         oe_n_of = data;
      end else if (os) begin
         oe_n_of = ~data;
      end else begin
         oe_n_of = 1'b0;
      end
   endfunction

   // Bus front end; all APB outputs leave from its flops.
   pmpc_apb_slave u_apb (
      .clock   (clock),
      .rstn    (rstn),
      .psel    (psel),
      .penable (penable),
      .pwrite  (pwrite),
      .paddr   (paddr),
      .pwdata  (pwdata),
      .pstrb   (pstrb),
      .prdata  (prdata),
      .pready  (pready),
      .pslverr (pslverr),
      .bus     (bus.slave)
   );

   // Next low drive word; only a bus strobe can change a field.
   always_comb begin
      b1_mode_lo_nxt = word_next(bus.wr_stb[pmpc_pkg::SEL_B1_LO], bus.wdata,
                                 pmpc_pkg::MASK_B1_MODE_LO, b1_mode_lo_r);
   end

   // Next high drive word; its reserved upper bits never store ones.
   always_comb begin
      b1_mode_hi_nxt = word_next(bus.wr_stb[pmpc_pkg::SEL_B1_HI], bus.wdata,
                                 pmpc_pkg::MASK_B1_MODE_HI, b1_mode_hi_r);
   end

   // Next pull selection word.
   always_comb begin
      b0_pull_lo_nxt = word_next(bus.wr_stb[pmpc_pkg::SEL_B0_PL], bus.wdata,
                                 pmpc_pkg::MASK_B0_PULL_LO, b0_pull_lo_r);
   end

   // Bank one low drive mode word.
   always_ff @(posedge clock) begin
      if (!rstn) begin
         b1_mode_lo_r <= pmpc_pkg::RST_B1_MODE_LO;
      end else begin
         b1_mode_lo_r <= b1_mode_lo_nxt;
      end
   end

   // Bank one high drive mode word.
   always_ff @(posedge clock) begin
      if (!rstn) begin
         b1_mode_hi_r <= pmpc_pkg::RST_B1_MODE_HI;
      end else begin
         b1_mode_hi_r <= b1_mode_hi_nxt;
      end
   end

   // Bank zero pull selection word; zero means every pin floats.
   always_ff @(posedge clock) begin
      if (!rstn) begin
         b0_pull_lo_r <= pmpc_pkg::RST_B0_PULL_LO;
      end else begin
         b0_pull_lo_r <= b0_pull_lo_nxt;
      end
   end

   // Register read multiplexer; reserved bits read zero because they never store ones.
   always_comb begin
      bus.rdata = pmpc_pkg::RST_ZERO;
      case (1'b1)
         bus.rd_sel[pmpc_pkg::SEL_B1_LO]: bus.rdata = b1_mode_lo_r;
         bus.rd_sel[pmpc_pkg::SEL_B1_HI]: bus.rdata = b1_mode_hi_r;
         bus.rd_sel[pmpc_pkg::SEL_B0_PL]: bus.rdata = b0_pull_lo_r;
         bus.rd_sel[pmpc_pkg::SEL_STAT]: begin
            bus.rdata[pmpc_pkg::B0_PINS-1:0] = b0_in_status;
         end
         default: bus.rdata = pmpc_pkg::RST_ZERO;
      endcase
   end

   // Bank one fields as one vector, from next values so pads move with the write.
   always_comb begin
      b1_fields_nxt = {b1_mode_hi_nxt[3:0], b1_mode_lo_nxt};
   end

   // Open-drain flags; the reserved code falls back to push-pull, the safest pad state.
   always_comb begin
      for (int i = 0; i < pmpc_pkg::B1_PINS; i++) begin
         od_nxt[i] = (field_of(b1_fields_nxt, i) == pmpc_pkg::PMPC_OPEN_DRAIN);
      end
   end

   // Open-source flags.
   always_comb begin
      for (int i = 0; i < pmpc_pkg::B1_PINS; i++) begin
         os_nxt[i] = (field_of(b1_fields_nxt, i) == pmpc_pkg::PMPC_OPEN_SOURCE);
      end
   end

   // Pad level follows the data one edge late in every mode.
   always_comb begin
      for (int i = 0; i < pmpc_pkg::B1_PINS; i++) begin
         drv_o_nxt[i] = b1_out_data[i];
      end
   end

   // Drive enables: open-drain drives only lows, open-source only highs.
   always_comb begin
      for (int i = 0; i < pmpc_pkg::B1_PINS; i++) begin
         drv_oe_n_nxt[i] = oe_n_of(od_nxt[i], os_nxt[i], b1_out_data[i]);
      end
   end

   // Bank one open-drain flags.
   always_ff @(posedge clock) begin
      if (!rstn) begin
         b1_open_drain_en <= '0;
      end else begin
         b1_open_drain_en <= od_nxt;
      end
   end

   // Bank one open-source flags.
   always_ff @(posedge clock) begin
      if (!rstn) begin
         b1_open_src_en <= '0;
      end else begin
         b1_open_src_en <= os_nxt;
      end
   end

   // Bank one pad levels; after reset every pin drives low.
   always_ff @(posedge clock) begin
      if (!rstn) begin
         b1_pad_o <= '0;
      end else begin
         b1_pad_o <= drv_o_nxt;
      end
   end

   // Bank one drive enables; after reset every pin is push-pull and driven.
   always_ff @(posedge clock) begin
      if (!rstn) begin
         b1_pad_oe_n <= '0;
      end else begin
         b1_pad_oe_n <= drv_oe_n_nxt;
      end
   end

   // Pull-up requests; analog is a code of its own, so it never shares a pull.
   always_comb begin
      for (int i = 0; i < pmpc_pkg::B0_PINS; i++) begin
         pu_nxt[i] = (field_of({4'h0, b0_pull_lo_nxt}, i) ==
                      pmpc_pkg::PMPC_PULL_UP);
      end
   end

   // Pull-down requests.
   always_comb begin
      for (int i = 0; i < pmpc_pkg::B0_PINS; i++) begin
         pd_nxt[i] = (field_of({4'h0, b0_pull_lo_nxt}, i) ==
                      pmpc_pkg::PMPC_PULL_DOWN);
      end
   end

   // Analog requests.
   always_comb begin
      for (int i = 0; i < pmpc_pkg::B0_PINS; i++) begin
         an_nxt[i] = (field_of({4'h0, b0_pull_lo_nxt}, i) ==
                      pmpc_pkg::PMPC_PULL_ANALOG);
      end
   end

   // Bank zero pull-up controls.
   always_ff @(posedge clock) begin
      if (!rstn) begin
         b0_pull_up_en <= '0;
      end else begin
         b0_pull_up_en <= pu_nxt;
      end
   end

   // Bank zero pull-down controls.
   always_ff @(posedge clock) begin
      if (!rstn) begin
         b0_pull_down_en <= '0;
      end else begin
         b0_pull_down_en <= pd_nxt;
      end
   end

   // Bank zero analog switches.
   always_ff @(posedge clock) begin
      if (!rstn) begin
         b0_analog_en <= '0;
      end else begin
         b0_analog_en <= an_nxt;
      end
   end

   // Input trigger is on for every non-analog pin; it is off in analog to save current.
   always_ff @(posedge clock) begin
      if (!rstn) begin
         b0_trig_en <= {pmpc_pkg::B0_PINS{1'b1}};
      end else begin
         b0_trig_en <= ~an_nxt;
      end
   end

   // Input status samples the pads, forced to zero for analog pins.
   always_ff @(posedge clock) begin
      if (!rstn) begin
         b0_in_status <= '0;
      end else begin
         b0_in_status <= b0_pad_in & ~an_nxt;
      end
   end

endmodule

// ===== bench/pmpc_top_properties.sv
`timescale 1ns/100ps
module pmpc_top_properties (
   input wire logic                         clock,            // Clock.
   input wire logic                         rstn,             // Reset, low.
   input wire logic                         psel,             // Select.
   input wire logic                         penable,          // Enable.
   input wire logic                         pwrite,           // Direction.
   input wire logic [pmpc_pkg::ADDR_W-1:0]  paddr,            // Address.
   input wire logic [pmpc_pkg::DATA_W-1:0]  pwdata,           // Write data.
   input wire logic [3:0]                   pstrb,            // Strobes.
   input wire logic                         pready,           // Ready.
   input wire logic [pmpc_pkg::B1_PINS-1:0] b1_out_data,      // Pad data.
   input wire logic [pmpc_pkg::B1_PINS-1:0] b1_pad_o,         // Pad level.
   input wire logic [pmpc_pkg::B1_PINS-1:0] b1_pad_oe_n,      // Drive enable.
   input wire logic [pmpc_pkg::B1_PINS-1:0] b1_open_drain_en, // Open drain.
   input wire logic [pmpc_pkg::B1_PINS-1:0] b1_open_src_en,   // Open source.
   input wire logic [pmpc_pkg::B0_PINS-1:0] b0_pad_in,        // Raw inputs.
   input wire logic [pmpc_pkg::B0_PINS-1:0] b0_in_status,     // Gated inputs.
   input wire logic [pmpc_pkg::B0_PINS-1:0] b0_pull_up_en,    // Pull-up.
   input wire logic [pmpc_pkg::B0_PINS-1:0] b0_pull_down_en,  // Pull-down.
   input wire logic [pmpc_pkg::B0_PINS-1:0] b0_analog_en,     // Analog.
   input wire logic [pmpc_pkg::B0_PINS-1:0] b0_trig_en        // Trigger.
);
   logic [1:0] top_code;
   logic       wr_pull;
   default clocking cb @(posedge clock); endclocking
   default disable iff (!rstn);
   // Top pull field and a completed full-word write to the pull word.
   assign top_code = pwdata[31:30];
   assign wr_pull  = psel && penable && pready && pwrite && paddr == 12'h010 && pstrb == 4'hF;
   a_pull_excl: assert property (
      (b0_pull_up_en & b0_pull_down_en) == '0 && (b0_analog_en & b0_pull_up_en) == '0)
      else $error("Pull enables overlap.");
   a_trig_analog: assert property (b0_trig_en == ~b0_analog_en)
      else $error("Trigger not tied to analog.");
   a_status_gate: assert property (
      rstn && $past(rstn) |-> b0_in_status == ($past(b0_pad_in) & ~b0_analog_en))
      else $error("Input status not gated.");
   a_drive_excl: assert property ((b1_open_drain_en & b1_open_src_en) == '0)
      else $error("Drive modes overlap.");
   a_rsvd_pins: assert property (
      {b1_open_drain_en[12], b1_open_drain_en[9], b1_open_drain_en[4], b1_open_src_en[12],
       b1_open_src_en[9], b1_open_src_en[4], b0_pull_up_en[3], b0_analog_en[3]} == '0)
      else $error("Reserved pin active.");
   a_oe_decode: assert property (
      b1_pad_oe_n == ((b1_open_drain_en & b1_pad_o) | (b1_open_src_en & ~b1_pad_o)))
      else $error("Drive enable wrong.");
   a_pad_follow: assert property (
      rstn && $past(rstn) |-> b1_pad_o == $past(b1_out_data))
      else $error("Pad level late.");
   a_pull_write: assert property (wr_pull |=>
      b0_analog_en[15] == ($past(top_code) == 2'h3) && b0_pull_up_en[15] == ($past(top_code) == 2'h1))
      else $error("Pull write not applied.");
   a_field_hold: assert property (!(psel && penable && pwrite) |=>
      $stable(b0_pull_up_en) && $stable(b0_analog_en) && $stable(b1_open_src_en))
      else $error("Field changed without write.");
   c_pull_write: cover property (wr_pull);
   c_analog: cover property (|b0_analog_en);
   c_src: cover property (|b1_open_src_en);
endmodule

// ===== bench/pmpc_top_tb.sv
`timescale 1ns/100ps
`define CHK(a, b) begin checks_done++; if ((a) !== (b)) begin mismatches++; \
   $display("BAD t=%0t got=%h exp=%h", $time, (a), (b)); end end
module pmpc_top_tb;
   logic        clock, rstn, psel, penable, pwrite, pready, pslverr, er;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, rd, d;
   logic [3:0]  pstrb;
   logic [17:0] b1_out_data, b1_pad_o, b1_pad_oe_n, b1_open_drain_en, b1_open_src_en;
   logic [15:0] b0_pad_in, b0_in_status, b0_pull_up_en, b0_pull_down_en, b0_analog_en, b0_trig_en;
   logic [31:0] sh [3];
   logic [11:0] ofs [3] = '{12'h008, 12'h00C, 12'h010};
   logic [31:0] msk [3] = '{32'hFCF3_FCFF, 32'h0000_000F, 32'hFFFF_FF3F};
   logic [31:0] cd [6] = '{32'hFFFF_FFFF, 32'hFFFF_FFFF, 32'hFFFF_FFFF, 32'h9999_9999,
                           32'h0000_0006, 32'h1B1B_1B1B};
   logic [11:0] ea [3] = '{12'h020, 12'h011, 12'h010};
   logic [3:0]  es [3] = '{4'hF, 4'hF, 4'h3};
   int          mismatches, checks_done, seed, k;
   pmpc_top i_pmpc_top (.clock(clock), .rstn(rstn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .b1_out_data(b1_out_data), .b1_pad_o(b1_pad_o),
      .b1_pad_oe_n(b1_pad_oe_n), .b1_open_drain_en(b1_open_drain_en),
      .b1_open_src_en(b1_open_src_en), .b0_pad_in(b0_pad_in), .b0_in_status(b0_in_status),
      .b0_pull_up_en(b0_pull_up_en), .b0_pull_down_en(b0_pull_down_en),
      .b0_analog_en(b0_analog_en), .b0_trig_en(b0_trig_en));
   // Free-running 40 MHz clock.
   initial begin
      clock = 1'b0;
      forever #12.5 clock = ~clock;
   end
   // Pins whose 2-bit field holds the given code.
   function automatic logic [17:0] dec(input logic [35:0] w, input logic [1:0] c);
      for (int i = 0; i < 18; i++) begin
         dec[i] = (w[2*i +: 2] == c);
      end
   endfunction
   task automatic close_out;
      if (mismatches == 0 && checks_done > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask
   // One APB transfer; the wait for ready is bounded so a dead slave cannot hang the run.
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] dt,
                      input logic [3:0] s);
      int n;
      psel    <= 1'b1;
      pwrite  <= w;
      paddr   <= a;
      pwdata  <= dt;
      pstrb   <= s;
      @(posedge clock);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge clock);
         n++;
      end while (pready !== 1'b1 && n < 16);
      if (n >= 16) begin
         mismatches++;
         close_out();
      end
      rd = prdata;
      er = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
      @(posedge clock);
   endtask
   task automatic rdchk(input logic [11:0] a, input logic [31:0] e);
      apb(1'b0, a, 32'h0, 4'h0);
      `CHK(rd, e)
      `CHK(er, 1'b0)
   endtask
   // Compare every pad control with the decode of the shadow words, off the clock edge.
   task automatic chk_pads;
      logic [17:0] od, os;
      logic [15:0] an;
      #1;
      od = dec({sh[1][3:0], sh[0]}, 2'h1);
      os = dec({sh[1][3:0], sh[0]}, 2'h2);
      an = 16'(dec({4'h0, sh[2]}, 2'h3));
      `CHK(b1_open_drain_en, od)
      `CHK(b1_open_src_en, os)
      `CHK(b1_pad_o, b1_out_data)
      `CHK(b1_pad_oe_n, (od & b1_out_data) | (os & ~b1_out_data))
      `CHK(b0_pull_up_en, 16'(dec({4'h0, sh[2]}, 2'h1)))
      `CHK(b0_pull_down_en, 16'(dec({4'h0, sh[2]}, 2'h2)))
      `CHK(b0_analog_en, an)
      `CHK(b0_trig_en, ~an)
      `CHK(b0_in_status, b0_pad_in & ~an)
      @(posedge clock);
   endtask
   // Main sequence: reset values, corner and random writes, refusals, second reset.
   initial begin
      seed = 81;
      mismatches = 0;
      checks_done = 0;
      rstn = 1'b0;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 12'h000;
      pwdata = 32'h0;
      pstrb = 4'h0;
      b1_out_data = 18'h0;
      b0_pad_in = 16'h0;
      sh = '{32'h0, 32'h0, 32'h0};
      repeat (4) @(posedge clock);
      rstn <= 1'b1;
      @(posedge clock);
      for (k = 0; k < 3; k++) rdchk(ofs[k], 32'h0);
      chk_pads();
      // First six passes are hand-picked words, the rest random; reserved bits read zero.
      for (int n = 0; n < 30; n++) begin
         k = (n < 6) ? n % 3 : $unsigned($random(seed)) % 3;
         d = ((n < 6) ? cd[n] : $random(seed)) & msk[k];
         b0_pad_in <= 16'($random(seed));
         b1_out_data <= 18'($random(seed));
         apb(1'b1, ofs[k], d, 4'hF);
         `CHK(er, 1'b0)
         sh[k] = d;
         rdchk(ofs[k], sh[k]);
         chk_pads();
      end
      // Refused writes leave every field alone.
      for (k = 0; k < 3; k++) begin
         apb(1'b1, ea[k], 32'hFFFF_FFFF, es[k]);
         `CHK(er, 1'b1)
      end
      rdchk(12'h010, sh[2]);
      chk_pads();
      rdchk(12'h040, {16'h0, b0_pad_in & ~16'(dec({4'h0, sh[2]}, 2'h3))});
      apb(1'b0, 12'h020, 32'h0, 4'h0);
      `CHK({er, rd}, {1'b1, 32'h0})
      rstn <= 1'b0;
      repeat (2) @(posedge clock);
      rstn <= 1'b1;
      @(posedge clock);
      sh = '{32'h0, 32'h0, 32'h0};
      for (k = 0; k < 3; k++) rdchk(ofs[k], 32'h0);
      chk_pads();
      close_out();
   end
endmodule
bind pmpc_top pmpc_top_properties i_props (.clock(clock), .rstn(rstn), .psel(psel),
   .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
   .pready(pready), .b1_out_data(b1_out_data), .b1_pad_o(b1_pad_o), .b1_pad_oe_n(b1_pad_oe_n),
   .b1_open_drain_en(b1_open_drain_en), .b1_open_src_en(b1_open_src_en),
   .b0_pad_in(b0_pad_in), .b0_in_status(b0_in_status), .b0_pull_up_en(b0_pull_up_en),
   .b0_pull_down_en(b0_pull_down_en), .b0_analog_en(b0_analog_en), .b0_trig_en(b0_trig_en));
